// ### verilog/pcr_pkg.sv
// Package: register map, field layout and reset values of the capability bank
package pcr_pkg;
    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [11:0] CAP_HEADER_ADDR  = 12'h040;
    localparam logic [11:0] DEV_CAPS_ADDR    = 12'h044;
    localparam logic [11:0] ADDR_MASK        = 12'hffc;

    // ------------------------------------------------------------
    // Capability header fields
    // ------------------------------------------------------------
    localparam logic [7:0]  CAP_ID_VALUE     = 8'h10;
    localparam int          NEXT_PTR_LSB     = 8;
    localparam int          REVISION_LSB     = 16;
    localparam logic [3:0]  REVISION_RESET   = 4'h2;
    localparam int          PORT_ROLE_LSB    = 20;
    localparam logic [3:0]  ROLE_UPSTREAM    = 4'h5;
    localparam logic [3:0]  ROLE_DOWNSTREAM  = 4'h6;
    localparam int          SLOT_BIT         = 24;
    localparam int          VECTOR_NUM_LSB   = 25;
    localparam logic [4:0]  VECTOR_NUM_VALUE = 5'h00;

    // ------------------------------------------------------------
    // Device capability fields
    // ------------------------------------------------------------
    localparam int          PAYLOAD_LSB      = 0;
    localparam logic [2:0]  PAYLOAD_RESET    = 3'h4;
    localparam logic [2:0]  PAYLOAD_MAX_CODE = 3'h5;
    localparam int          PHANTOM_LSB      = 3;
    localparam int          EXT_TAG_BIT      = 5;
    localparam logic        EXT_TAG_RESET    = 1'b1;
    localparam int          SHALLOW_LAT_LSB  = 6;
    localparam int          DEEP_LAT_LSB     = 9;
    localparam int          ATTN_BUTTON_BIT  = 12;

    // ------------------------------------------------------------
    // AHB encodings
    // ------------------------------------------------------------
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ       = 2'h3;
    localparam logic [2:0]  HSIZE_WORD       = 3'h2;
endpackage

// ### verilog/pcr_capability_regs.sv
// Capability register bank of one switch port behind an AHB-Lite slave
//
// Function
// (RULE1) Header low byte reads fixed capability identifier 0x10.
// (RULE2) Header bits 15:8 hold next pointer, writable when lock is open.
// (RULE3) Header bits 19:16 hold revision, reset 0x2, writable when unlocked.
// (RULE4) Header bits 23:20 read port role: 0x5 upstream, 0x6 downstream.
// (RULE5) Header bit 24 slot flag, resets zero, writable when unlocked.
// (RULE6) Software keeps slot flag cleared on the upstream port.
// (RULE7) Header bits 29:25 interrupt vector number read as zero.
// (RULE8) Payload size bits 2:0, reset 0x4, codes 0..5 mean 128..4096 bytes.
// (RULE9) Payload codes six and seven behave as 128 bytes.
// (RULE10) Phantom function bits 4:3 hardwired zero.
// (RULE11) Extended tag bit 5, resets one, writable when unlocked.
// (RULE12) Shallow exit latency bits 8:6 hardwired zero.
// (RULE13) Deep exit latency bits 11:9 hardwired zero.
// (RULE14) Attention button bit 12 reads zero, read-only.
// (RULE15) Writes to read-only or reserved bits ignored; reserved bits read zero.
`timescale 1ns/1ps

module pcr_capability_regs #(
    parameter logic [7:0] NEXT_PTR_RESET = 8'h00
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        upstream_port,
    input  wire logic        lockable_write_type,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [2:0]  payload_bytes_code
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic       role_sync_r;
    logic       lock_sync_r;

    // Strap and lock levels come from pins; two stages each before any use
    pcr_sync2 #(
        .WIDTH    (1)
    ) u_role_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in (upstream_port),
        .sync_r   (role_sync_r)
    );

    pcr_sync2 #(
        .WIDTH    (1)
    ) u_lock_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in (lockable_write_type),
        .sync_r   (lock_sync_r)
    );

    // ------------------------------------------------------------
    // AHB address phase capture
    // ------------------------------------------------------------
    logic        wr_pend_r;
    logic [11:0] wr_addr_r;
    logic        rd_pend_r;
    logic [11:0] rd_addr_r;
    logic        take;
    logic        active;
    logic        word_size;

    // Only NONSEQ and SEQ carry a transfer; IDLE and BUSY leave the bank alone
    assign active = (htrans == pcr_pkg::HTRANS_NONSEQ) || (htrans == pcr_pkg::HTRANS_SEQ);
    assign take   = hsel && hready && active;

    // Narrower writes would tear a field, so only whole words may land
    assign word_size = (hsize == pcr_pkg::HSIZE_WORD);

    // Latch a transfer for its data phase
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
            rd_addr_r <= 12'h000;
        end else begin
            wr_pend_r <= take && hwrite && word_size;
            rd_pend_r <= take && !hwrite;
            if (take) begin
                wr_addr_r <= haddr & pcr_pkg::ADDR_MASK;
                rd_addr_r <= haddr & pcr_pkg::ADDR_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // Writable fields
    // ------------------------------------------------------------
    logic [7:0] next_ptr_r;
    logic [3:0] revision_r;
    logic       slot_r;
    logic [2:0] payload_r;
    logic       ext_tag_r;
    logic       hdr_wr;
    logic       dev_wr;

    assign hdr_wr = wr_pend_r && lock_sync_r && (wr_addr_r == pcr_pkg::CAP_HEADER_ADDR);
    assign dev_wr = wr_pend_r && lock_sync_r && (wr_addr_r == pcr_pkg::DEV_CAPS_ADDR);

    // Next pointer, reset value chosen by the integrator
    pcr_field_reg #(
        .WIDTH       (8),
        .RESET_VALUE (NEXT_PTR_RESET)
    ) u_next_ptr (
        .clk         (clk),
        .reset       (reset),
        .write_en    (hdr_wr),
        .write_data  (hwdata[pcr_pkg::NEXT_PTR_LSB +: 8]),     // RULE2
        .value_r     (next_ptr_r)
    );

    // Structure revision
    pcr_field_reg #(
        .WIDTH       (4),
        .RESET_VALUE (pcr_pkg::REVISION_RESET)
    ) u_revision (
        .clk         (clk),
        .reset       (reset),
        .write_en    (hdr_wr),
        .write_data  (hwdata[pcr_pkg::REVISION_LSB +: 4]),     // RULE3
        .value_r     (revision_r)
    );

    // Slot flag; keeping it clear on the upstream port is software's duty
    pcr_field_reg #(
        .WIDTH       (1),
        .RESET_VALUE (1'b0)
    ) u_slot (
        .clk         (clk),
        .reset       (reset),
        .write_en    (hdr_wr),
        .write_data  (hwdata[pcr_pkg::SLOT_BIT]),              // RULE5
        .value_r     (slot_r)
    );

    // Stored payload code, read back raw including reserved codes
    pcr_field_reg #(
        .WIDTH       (3),
        .RESET_VALUE (pcr_pkg::PAYLOAD_RESET)
    ) u_payload (
        .clk         (clk),
        .reset       (reset),
        .write_en    (dev_wr),
        .write_data  (hwdata[pcr_pkg::PAYLOAD_LSB +: 3]),      // RULE8
        .value_r     (payload_r)
    );

    // Extended tag support
    pcr_field_reg #(
        .WIDTH       (1),
        .RESET_VALUE (pcr_pkg::EXT_TAG_RESET)
    ) u_ext_tag (
        .clk         (clk),
        .reset       (reset),
        .write_en    (dev_wr),
        .write_data  (hwdata[pcr_pkg::EXT_TAG_BIT]),           // RULE11
        .value_r     (ext_tag_r)
    );

    // ------------------------------------------------------------
    // Effective payload size
    // ------------------------------------------------------------
    // Reserved codes fall back to the smallest size
    always_ff @(posedge clk) begin
        if (reset) begin
            payload_bytes_code <= 3'h0;
        end else if (payload_r > pcr_pkg::PAYLOAD_MAX_CODE) begin
            payload_bytes_code <= 3'h0;                         // RULE9
        end else begin
            payload_bytes_code <= payload_r;                    // RULE8
        end
    end

    // ------------------------------------------------------------
    // Read words
    // ------------------------------------------------------------
    logic [31:0] hdr_word;
    logic [31:0] dev_word;
    logic [3:0]  role_code;

    assign role_code = role_sync_r ? pcr_pkg::ROLE_UPSTREAM : pcr_pkg::ROLE_DOWNSTREAM;  // RULE4

    // Header assembly, unused bits zero
    always_comb begin
        hdr_word = 32'h0000_0000;                                       // RULE15
        hdr_word[7:0] = pcr_pkg::CAP_ID_VALUE;                          // RULE1
        hdr_word[pcr_pkg::NEXT_PTR_LSB +: 8] = next_ptr_r;              // RULE2
        hdr_word[pcr_pkg::REVISION_LSB +: 4] = revision_r;              // RULE3
        hdr_word[pcr_pkg::PORT_ROLE_LSB +: 4] = role_code;              // RULE4
        hdr_word[pcr_pkg::SLOT_BIT] = slot_r;                           // RULE5
        hdr_word[pcr_pkg::VECTOR_NUM_LSB +: 5] = pcr_pkg::VECTOR_NUM_VALUE;  // RULE7
    end

    // Device capability assembly, hardwired fields zero
    always_comb begin
        dev_word = 32'h0000_0000;                                       // RULE15
        dev_word[pcr_pkg::PAYLOAD_LSB +: 3] = payload_r;                // RULE8
        dev_word[pcr_pkg::PHANTOM_LSB +: 2] = 2'h0;                     // RULE10
        dev_word[pcr_pkg::EXT_TAG_BIT] = ext_tag_r;                     // RULE11
        dev_word[pcr_pkg::SHALLOW_LAT_LSB +: 3] = 3'h0;                 // RULE12
        dev_word[pcr_pkg::DEEP_LAT_LSB +: 3] = 3'h0;                    // RULE13
        dev_word[pcr_pkg::ATTN_BUTTON_BIT] = 1'b0;                      // RULE14
    end

    // ------------------------------------------------------------
    // Response path
    // ------------------------------------------------------------
    // Word selected by the address held from the address phase
    logic [31:0] rd_word;

    always_comb begin
        rd_word = 32'h0000_0000;                                        // RULE15
        if (rd_addr_r == pcr_pkg::CAP_HEADER_ADDR) begin
            rd_word = hdr_word;
        end else if (rd_addr_r == pcr_pkg::DEV_CAPS_ADDR) begin
            rd_word = dev_word;
        end
    end

    // One wait state on every read: low in the first data cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            hreadyout <= 1'b1;
        end else if (take && !hwrite) begin
            hreadyout <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    // Read data loaded as the wait state ends, held until the next read
    always_ff @(posedge clk) begin
        if (reset) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_pend_r) begin
            hrdata <= rd_word;
        end
    end

    // Always OKAY
    always_ff @(posedge clk) begin
        if (reset) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

endmodule

// ------------------------------------------------------------
// Two-stage synchroniser for pin levels
// ------------------------------------------------------------
// Only the second stage is read outside, so a metastable first
// stage never reaches the decode logic
module pcr_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_r
);

    logic [WIDTH-1:0] meta_r;

    // Both stages clear with the bank
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

endmodule

// ------------------------------------------------------------
// Lockable field register
// ------------------------------------------------------------
// Holds one field; loads only on a qualified write strobe
module pcr_field_reg #(
    parameter int               WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             write_en,
    input  wire logic [WIDTH-1:0] write_data,
    output logic      [WIDTH-1:0] value_r
);

    // Write strobe already carries the lock, the size and the address match
    always_ff @(posedge clk) begin
        if (reset) begin
            value_r <= RESET_VALUE;
        end else if (write_en) begin
            value_r <= write_data;
        end
    end

endmodule

// ### testbench/pcr_caps_props.sv
// Checker for the capability bank ports
`timescale 1ns/1ps
module pcr_caps_props (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        upstream_port,
    input wire logic        lockable_write_type,
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [2:0]  payload_bytes_code
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Cycles the lock level has held, saturating at 7
    logic [2:0] lk_cnt_r;
    logic       lk_q_r;
    always_ff @(posedge clk) begin
        lk_q_r <= lockable_write_type;
        if (reset || lockable_write_type != lk_q_r) lk_cnt_r <= 3'h0;
        else if (lk_cnt_r != 3'h7) lk_cnt_r <= lk_cnt_r + 3'h1;
    end
    // Decoded transfers taken at this edge
    wire req     = hsel && hready && htrans[1];
    wire rd_hdr  = req && !hwrite && haddr[11:2] == 10'h010;
    wire rd_dev  = req && !hwrite && haddr[11:2] == 10'h011;
    wire wr_dev  = req && hwrite && hsize == 3'h2 && haddr[11:2] == 10'h011;
    wire settled = lk_cnt_r == 3'h7;
    sequence rd_done_q;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence dev_wr_open_q;
        wr_dev && lockable_write_type && settled;
    endsequence
    // Data phase one edge after the request, effective code two edges later
    property code_follows_p;
        dev_wr_open_q |-> ##3 payload_bytes_code == ($past(hwdata[2:0], 2) > 3'h5 ? 3'h0 : $past(hwdata[2:0], 2));
    endproperty
    read_wait_state_a: assert property (rd_hdr || rd_dev |=> rd_done_q)
        else $error("read wait state wrong");
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    cap_id_a: assert property (rd_hdr |-> ##2 hrdata[7:0] == 8'h10)
        else $error("capability id wrong");
    vector_zero_a: assert property (rd_hdr |-> ##2 hrdata[31:25] == 7'h00)
        else $error("vector number not zero");
    port_role_a: assert property (rd_hdr |-> ##2 hrdata[23:20] == ($past(upstream_port, 3) ? 4'h5 : 4'h6))
        else $error("port role wrong");
    fixed_caps_a: assert property (rd_dev |-> ##2 {hrdata[31:6], hrdata[4:3]} == 28'h0)
        else $error("hardwired caps not zero");
    locked_payload_a: assert property (wr_dev && settled && !lockable_write_type |=> $stable(payload_bytes_code)[*3])
        else $error("locked write changed payload");
    payload_fallback_a: assert property (code_follows_p)
        else $error("payload code wrong");
    code_range_a: assert property (payload_bytes_code <= 3'h5)
        else $error("payload code reserved");
endmodule
bind pcr_capability_regs pcr_caps_props u_props (.clk(clk), .reset(reset), .upstream_port(upstream_port),
    .lockable_write_type(lockable_write_type), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .payload_bytes_code(payload_bytes_code));

// ### testbench/tb_pcie_capability_regs.sv
// Directed bus test of the capability bank
`timescale 1ns/1ps
module tb_pcie_capability_regs;
    logic        clk;
    logic        reset;
    logic        upstream_port;
    logic        lockable_write_type;
    logic        hsel;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [2:0]  payload_bytes_code;
    logic [31:0] got;
    int          failures;
    int          compares;
    int          cycles;
    wire         hready = hreadyout;
    pcr_capability_regs dut (.clk(clk), .reset(reset), .upstream_port(upstream_port),
        .lockable_write_type(lockable_write_type), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .payload_bytes_code(payload_bytes_code));
    // ----
    // Bus tasks
    // ----
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            failures++;
            $display("wrong value at %0t: %h expected %h", $time, seen, want);
        end
    endtask
    // One single transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= pcr_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        got = hrdata;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] want);
        bus(1'b0, a, 32'h0);
        chk(got, want);
    endtask
    task automatic finish_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            finish_test;
        end
    end
    // Test sequence
    initial begin
        reset = 1'b1;
        upstream_port = 1'b0;
        lockable_write_type = 1'b0;
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        rd(12'h040, 32'h0062_0010);
        rd(12'h044, 32'h0000_0024);
        chk({29'h0, payload_bytes_code}, 32'h4);
        $display("reset values done");
        bus(1'b1, 12'h040, 32'hffff_ffff);
        bus(1'b1, 12'h044, 32'hffff_ffff);
        rd(12'h040, 32'h0062_0010);
        rd(12'h044, 32'h0000_0024);
        rd(12'h048, 32'h0);
        $display("locked writes done");
        lockable_write_type <= 1'b1;
        repeat (8) @(posedge clk);
        bus(1'b1, 12'h040, 32'hffff_ffff);
        rd(12'h040, 32'h016f_ff10);
        bus(1'b1, 12'h044, 32'hffff_ffff);
        rd(12'h044, 32'h0000_0027);
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, 12'h044, 32'(c));
            rd(12'h044, 32'(c));
            chk({29'h0, payload_bytes_code}, c > 5 ? 32'h0 : 32'(c));
        end
        hsize <= 3'h0;
        bus(1'b1, 12'h044, 32'h0000_0001);
        hsize <= 3'h2;
        rd(12'h044, 32'h0000_0007);
        $display("open writes done");
        upstream_port <= 1'b1;
        bus(1'b1, 12'h040, 32'h0);
        repeat (4) @(posedge clk);
        rd(12'h040, 32'h0050_0010);
        $display("upstream role done");
        finish_test;
    end
endmodule
